// ### rx_fifo_threshold_config.sv
/*
 * Receive queue of a serial unit with its setup register, fill-level
 * threshold interrupt and an Avalon-MM register slave with waitrequest.
 * Assumes received bytes arrive from the serial engine on core_clk,
 * one byte per rx_byte_valid pulse.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rx_fifo_cfg.svh"

module rx_fifo_threshold_config
    import rx_fifo_pkg::*;
(
    input  wire logic        core_clk,       // 125 MHz clock
    input  wire logic        rst,            // async reset, active high
    input  wire logic [7:0]  address,        // byte address
    input  wire logic        read,           // read request
    input  wire logic        write,          // write request
    input  wire logic [31:0] writedata,      // write data
    input  wire logic [3:0]  byteenable,     // byte lanes
    output logic      [31:0] readdata,       // read data
    output logic             waitrequest,    // stall master
    input  wire logic [7:0]  rx_byte,        // byte from serial engine
    input  wire logic        rx_byte_valid,  // byte strobe
    output logic      [2:0]  rx_level,       // fill level to unit
    output logic             rx_irq_req,     // threshold condition
    output logic             queue_enable,   // queue enable to unit
    output logic             full_duplex,    // duplex select to unit
    output logic             irq             // level interrupt
);

    // threshold code to byte count
    function automatic level_type thr_bytes(input logic [1:0] code,
                                            input logic       fdx);
        level_type t;
        t = `THR_ANY_01;
        case (code)
            2'h0: begin
                t = fdx ? `THR_FULL_00 : `THR_HALF_00;
            end
            2'h2: begin
                t = fdx ? `THR_FULL_10 : `THR_HALF_10;
            end
            2'h3: begin
                t = fdx ? `THR_FULL_11 : `THR_HALF_11;
            end
            default: begin
                t = `THR_ANY_01;
            end
        endcase
        return t;
    endfunction : thr_bytes

    bus_state_type bus_state_r;
    bus_state_type bus_state_nxt;
    rx_cfg_type    rx_cfg_r;
    unit_cfg_type  unit_cfg_r;
    logic [7:0]    mem_r [4];
    logic [1:0]    wr_ptr_r;
    logic [1:0]    rd_ptr_r;
    level_type     level_r;
    level_type     level_nxt;
    logic [1:0]    irq_stat_r;
    logic [1:0]    irq_stat_nxt;
    logic [1:0]    irq_mask_r;
    logic          cond_prev_r;
    logic [31:0]   readdata_r;
    logic          waitrequest_r;

    // bus decode
    wire logic access   = read | write;
    wire logic commit   = access & (bus_state_r == BUS_ANSWER);
    wire logic wr_lane0 = write & commit & byteenable[0];
    wire logic rd_now   = read & commit;
    wire logic sel_setup  = (address == `RQ_SETUP_OFS);
    wire logic sel_qsetup = (address == `QUEUE_SETUP_OFS);
    wire logic sel_status = (address == `RQ_STATUS_OFS);
    wire logic sel_data   = (address == `RQ_DATA_OFS);
    wire logic sel_istat  = (address == `IRQ_STATUS_OFS);
    wire logic sel_imask  = (address == `IRQ_MASK_OFS);

    // write strobes per register
    wire logic wr_setup  = wr_lane0 & sel_setup;
    wire logic wr_qsetup = wr_lane0 & sel_qsetup;
    wire logic wr_istat  = wr_lane0 & sel_istat;
    wire logic wr_imask  = wr_lane0 & sel_imask;

    // a flush beats a same-cycle push: the byte is lost, an overrun is flagged only if the queue had no room
    wire logic flush = wr_setup & writedata[`FLUSH_BIT];

    // queue capacity by mode
    // nine-bit mode or a disabled queue leaves one holding byte
    wire logic    usable = unit_cfg_r.queue_enable & ~unit_cfg_r.nine_bit_mode;
    wire level_type cap  = !usable ? `DEPTH_PLAIN :
                           unit_cfg_r.full_duplex ? `DEPTH_FULL :
                           `DEPTH_HALF;

    wire logic pop  = rd_now & sel_data & (level_r != 3'h0);
    wire logic room = (level_r < cap) | pop;
    wire logic push = rx_byte_valid & room & ~flush;
    wire logic ovr  = rx_byte_valid & ~room;

    // threshold compare
    wire level_type thr = thr_bytes(rx_cfg_r.threshold_code,
                                    unit_cfg_r.full_duplex);
    wire logic cond_eq = (level_r == thr);
    wire logic cond_ge = (level_r >= thr);
    wire logic cond = usable &
                      (rx_cfg_r.rx_irq_compare_select ? cond_ge : cond_eq);
    wire logic cond_rise = cond & ~cond_prev_r;

    // read mux
    wire logic [31:0] rd_setup  = {24'h000000, 1'b0,
                                   rx_cfg_r.rx_irq_compare_select,
                                   4'h0, rx_cfg_r.threshold_code};
    wire logic [31:0] rd_qsetup = {29'h00000000, unit_cfg_r};
    wire logic [31:0] rd_status = {29'h00000000, level_r};
    wire logic [31:0] rd_data   = (level_r != 3'h0) ?
                                  {24'h000000, mem_r[rd_ptr_r]} : 32'h00000000;
    wire logic [31:0] rd_istat  = {30'h00000000, irq_stat_r};
    wire logic [31:0] rd_imask  = {30'h00000000, irq_mask_r};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (sel_setup) begin
            rd_mux = rd_setup;
        end else if (sel_qsetup) begin
            rd_mux = rd_qsetup;
        end else if (sel_status) begin
            rd_mux = rd_status;
        end else if (sel_data) begin
            rd_mux = rd_data;
        end else if (sel_istat) begin
            rd_mux = rd_istat;
        end else if (sel_imask) begin
            rd_mux = rd_imask;
        end
    end

    // one wait cycle, then the answer
    always_comb begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            BUS_IDLE: begin
                if (access) begin
                    bus_state_nxt = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_state_r   <= BUS_IDLE;
            waitrequest_r <= 1'b1;
            readdata_r    <= 32'h00000000;
        end else begin
            bus_state_r   <= bus_state_nxt;
            waitrequest_r <= ~(bus_state_nxt == BUS_ANSWER);
            // latched on the request edge; a data pop lands one edge later
            if (read & (bus_state_r == BUS_IDLE)) begin
                readdata_r <= rd_mux;
            end
        end
    end

    // configuration registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_cfg_r.rx_irq_compare_select <= 1'(`SETUP_RESET >> `CMP_SEL_BIT);
            rx_cfg_r.threshold_code        <= 2'(`SETUP_RESET >> `THR_LSB);
        end else if (wr_setup) begin
            rx_cfg_r.rx_irq_compare_select <= writedata[`CMP_SEL_BIT];
            rx_cfg_r.threshold_code        <= writedata[`THR_MSB:`THR_LSB];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            unit_cfg_r <= `QSETUP_RESET;
        end else if (wr_qsetup) begin
            unit_cfg_r.queue_enable  <= writedata[`ENABLE_BIT];
            unit_cfg_r.full_duplex   <= writedata[`DUPLEX_BIT];
            unit_cfg_r.nine_bit_mode <= writedata[`NINE_BIT_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_mask_r <= `MASK_RESET;
        end else if (wr_imask) begin
            irq_mask_r <= writedata[1:0];
        end
    end

    // queue storage
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_entry
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    mem_r[gi] <= 8'h00;
                end else if (push && wr_ptr_r == 2'(gi)) begin
                    mem_r[gi] <= rx_byte;
                end
            end
        end
    endgenerate

    always_comb begin
        level_nxt = level_r;
        if (flush) begin
            level_nxt = 3'h0;
        end else if (push & ~pop) begin
            level_nxt = level_r + 3'h1;
        end else if (pop & ~push) begin
            level_nxt = level_r - 3'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level_r <= 3'h0;
        end else begin
            level_r <= level_nxt;
        end
    end

    // pointers wrap on four entries; smaller capacities simply stop early
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= 2'h0;
            rd_ptr_r <= 2'h0;
        end else if (flush) begin
            wr_ptr_r <= 2'h0;
            rd_ptr_r <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
        end
    end

    // sticky events; a new event beats a same-cycle clear
    // the threshold bit takes the rising edge, so a standing level cannot re-set it
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (wr_istat) begin
            irq_stat_nxt = irq_stat_r & ~writedata[1:0];
        end
        if (cond_rise) begin
            irq_stat_nxt[`IRQ_THR_BIT] = 1'b1;
        end
        if (ovr) begin
            irq_stat_nxt[`IRQ_OVR_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_stat_r  <= 2'h0;
            cond_prev_r <= 1'b0;
        end else begin
            irq_stat_r  <= irq_stat_nxt;
            cond_prev_r <= cond;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_level     <= 3'h0;
            rx_irq_req   <= 1'b0;
            queue_enable <= 1'b0;
            full_duplex  <= 1'b0;
            irq          <= 1'b0;
        end else begin
            rx_level     <= level_nxt;
            rx_irq_req   <= cond;
            queue_enable <= unit_cfg_r.queue_enable;
            full_duplex  <= unit_cfg_r.full_duplex;
            irq          <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    assign readdata    = readdata_r;
    assign waitrequest = waitrequest_r;

endmodule : rx_fifo_threshold_config
`default_nettype wire

// ### rx_fifo_cfg.svh
/*
 * Address map, field positions, reset values and sizes of the receive queue setup block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one register per aligned word.
 */
`ifndef RX_FIFO_CFG_SVH
`define RX_FIFO_CFG_SVH

`define RQ_SETUP_OFS      8'h00
`define QUEUE_SETUP_OFS   8'h04
`define RQ_STATUS_OFS     8'h08
`define RQ_DATA_OFS       8'h0C
`define IRQ_STATUS_OFS    8'h10
`define IRQ_MASK_OFS      8'h14

`define FLUSH_BIT         7
`define CMP_SEL_BIT       6
`define THR_MSB           1
`define THR_LSB           0

`define ENABLE_BIT        0
`define DUPLEX_BIT        1
`define NINE_BIT_BIT      2

`define IRQ_THR_BIT       0
`define IRQ_OVR_BIT       1

`define SETUP_RESET       32'h00000000
`define QSETUP_RESET      3'h0
`define MASK_RESET        2'h0

`define DEPTH_HALF        3'h4
`define DEPTH_FULL        3'h2
`define DEPTH_PLAIN       3'h1

`define THR_HALF_00       3'h4
`define THR_FULL_00       3'h2
`define THR_HALF_10       3'h2
`define THR_FULL_10       3'h2
`define THR_HALF_11       3'h3
`define THR_FULL_11       3'h1
`define THR_ANY_01        3'h1

`endif

// ### rx_fifo_pkg.sv
/*
 * Types shared by the receive queue setup block.
 * Assumes rx_fifo_cfg.svh supplies the numeric constants.
 */
package rx_fifo_pkg;

    typedef logic [2:0] level_type;

    typedef struct packed {
        logic       rx_irq_compare_select;
        logic [1:0] threshold_code;
    } rx_cfg_type;

    typedef struct packed {
        logic nine_bit_mode;
        logic full_duplex;
        logic queue_enable;
    } unit_cfg_type;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_type;

endpackage : rx_fifo_pkg

// ### rx_fifo_cfg_checker.sv
/* assertions on the ports of rx_fifo_threshold_config
   assumes the register map and field positions of rx_fifo_cfg.svh */
`timescale 1ns/1ns
`default_nettype none
`include "rx_fifo_cfg.svh"
module rx_fifo_cfg_checker
    import rx_fifo_pkg::*;
(
    input wire logic        core_clk,      // clock
    input wire logic        rst,           // reset
    input wire logic [7:0]  address,       // address
    input wire logic        read,          // read
    input wire logic        write,         // write
    input wire logic [31:0] writedata,     // data in
    input wire logic [3:0]  byteenable,    // lanes
    input wire logic [31:0] readdata,      // data out
    input wire logic        waitrequest,   // stall
    input wire logic [7:0]  rx_byte,       // byte
    input wire logic        rx_byte_valid, // strobe
    input wire logic [2:0]  rx_level,      // level
    input wire logic        rx_irq_req,    // condition
    input wire logic        queue_enable,  // enable
    input wire logic        full_duplex,   // duplex
    input wire logic        irq            // interrupt
);
    logic [2:0] cfg_r;
    logic       nine_r;
    logic       en_r;
    logic       fdx_r;
    wire        wr_take = write && !waitrequest && byteenable[0];
    wire  [2:0] thr = (cfg_r[1:0] == 2'h1) ? 3'h1 : fdx_r ? ((cfg_r[1:0] == 2'h3) ? 3'h1 : 3'h2)
                    : ((cfg_r[1:0] == 2'h0) ? 3'h4 : {1'b0, cfg_r[1:0]});
    wire        cond = en_r && !nine_r && (cfg_r[2] ? rx_level >= thr : rx_level == thr);
    // shadow of the written setup fields
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_r  <= 3'h0;
            nine_r <= 1'b0;
            en_r   <= 1'b0;
            fdx_r  <= 1'b0;
        end else if (wr_take) begin
            if (address == `RQ_SETUP_OFS) cfg_r <= {writedata[6], writedata[1:0]};
            if (address == `QUEUE_SETUP_OFS) begin
                nine_r <= writedata[2];
                en_r   <= writedata[0];
                fdx_r  <= writedata[1];
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_wait_one; !waitrequest |=> waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low twice");
    property p_wait_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
    property p_flush; wr_take && address == `RQ_SETUP_OFS && writedata[7] |=> rx_level == 3'h0; endproperty
    a_flush: assert property (p_flush) else $error("flush left bytes");
    property p_cap_full; full_duplex |-> rx_level <= 3'h2; endproperty
    a_cap_full: assert property (p_cap_full) else $error("full duplex level above two");
    property p_cap_off; !queue_enable |-> rx_level <= 3'h1; endproperty
    a_cap_off: assert property (p_cap_off) else $error("queue used while disabled");
    property p_inc; rx_byte_valid && rx_level == 3'h0 && !write |=> rx_level == 3'h1; endproperty
    a_inc: assert property (p_inc) else $error("byte not counted");
    property p_req; rx_irq_req == $past(cond); endproperty
    a_req: assert property (p_req) else $error("threshold condition wrong");
    property p_rsv; read && !waitrequest && address == `RQ_SETUP_OFS |-> readdata[31:7] == 25'h0 && readdata[5:2] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
endmodule : rx_fifo_cfg_checker
bind rx_fifo_threshold_config rx_fifo_cfg_checker i_chk (.core_clk, .rst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .rx_byte, .rx_byte_valid, .rx_level, .rx_irq_req, .queue_enable,
    .full_duplex, .irq);
`default_nettype wire

// ### testbench.sv
/* self-checking bench for rx_fifo_threshold_config
   assumes one wait cycle per bus access and bytes pushed on core_clk */
`timescale 1ns/1ns
`default_nettype none
`include "rx_fifo_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module testbench
    import rx_fifo_pkg::*;
;
    logic        core_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, rx_byte_valid = 1'b0;
    logic [7:0]  address = 8'h00, rx_byte = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [3:0]  byteenable = 4'hF;
    logic [2:0]  rx_level;
    logic        waitrequest, rx_irq_req, queue_enable, full_duplex, irq;
    // duplex, compare, code[1:0], bytes[2:0], expected request
    logic [7:0]  rows [11] = '{8'h09, 8'h13, 8'h26, 8'h67, 8'h37, 8'h46, 8'h85, 8'h94, 8'hD5, 8'hA2, 8'hB3};
    int          fails = 0, n_tests = 0;
    rx_fifo_threshold_config i_dut (.core_clk, .rst, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .rx_byte, .rx_byte_valid, .rx_level, .rx_irq_req, .queue_enable,
        .full_duplex, .irq);
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        k = 0;
        do begin @(posedge core_clk); k++; end while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            fails++;
            finish_test();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic push(input logic [2:0] n, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            rx_byte <= b + 8'(i);
            rx_byte_valid <= 1'b1;
        end
        @(posedge core_clk);
        rx_byte_valid <= 1'b0;
    endtask : push
    initial begin
        @(negedge core_clk);
        `CHK("wait_rst", 1'b1, waitrequest)
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        bus(0, `RQ_SETUP_OFS, 0);
        `CHK("setup_rst", 32'h0, q)
        bus(0, `QUEUE_SETUP_OFS, 0);
        `CHK("qsetup_rst", 32'h0, q)
        foreach (rows[i]) begin
            bus(1, `RQ_SETUP_OFS, 32'h80);
            @(negedge core_clk);
            `CHK("flush_level", 3'h0, rx_level)
            bus(1, `QUEUE_SETUP_OFS, {30'h0, rows[i][7], 1'b1});
            bus(1, `RQ_SETUP_OFS, {24'h0, 1'b1, rows[i][6], 4'h0, rows[i][5:4]});
            push(rows[i][3:1], 8'h10);
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            `CHK("row_level", rows[i][3:1], rx_level)
            `CHK("row_req", rows[i][0], rx_irq_req)
        end
        bus(1, `QUEUE_SETUP_OFS, 32'h1);
        bus(1, `RQ_SETUP_OFS, 32'h80);
        push(3'h2, 8'hA0);
        bus(0, `RQ_DATA_OFS, 0);
        `CHK("pop_first", 32'hA0, q)
        bus(1, `RQ_SETUP_OFS, 32'h80);
        push(3'h1, 8'hB0);
        bus(0, `RQ_DATA_OFS, 0);
        `CHK("pop_after_flush", 32'hB0, q)
        bus(0, `RQ_DATA_OFS, 0);
        `CHK("pop_empty", 32'h0, q)
        bus(1, `QUEUE_SETUP_OFS, 32'h3);
        bus(1, `RQ_SETUP_OFS, 32'h80);
        bus(1, `IRQ_MASK_OFS, 32'h2);
        bus(1, `IRQ_STATUS_OFS, 32'h3);
        push(3'h3, 8'hC0);
        @(negedge core_clk);
        `CHK("full_level", 3'h2, rx_level)
        `CHK("irq_ovr", 1'b1, irq)
        `CHK("modes", 2'h3, {full_duplex, queue_enable})
        bus(0, `RQ_STATUS_OFS, 0);
        `CHK("status_level", 32'h2, q)
        bus(0, `IRQ_STATUS_OFS, 0);
        `CHK("irq_bits", 2'h3, q[1:0])
        bus(1, `IRQ_STATUS_OFS, 32'h3);
        @(negedge core_clk);
        `CHK("irq_clear", 1'b0, irq)
        bus(0, 8'hFC, 0);
        `CHK("unmapped", 32'h0, q)
        bus(1, `RQ_SETUP_OFS, 32'hFFFFFFFF);
        bus(0, `RQ_SETUP_OFS, 0);
        `CHK("setup_rb", 32'h43, q)
        byteenable <= 4'h0;
        bus(1, `RQ_SETUP_OFS, 32'h0);
        byteenable <= 4'hF;
        bus(0, `RQ_SETUP_OFS, 0);
        `CHK("lane_off", 32'h43, q)
        bus(1, `QUEUE_SETUP_OFS, 32'h5);
        bus(1, `RQ_SETUP_OFS, 32'h81);
        push(3'h2, 8'hD0);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("nine_level", 3'h1, rx_level)
        `CHK("nine_req", 1'b0, rx_irq_req)
        bus(0, `IRQ_STATUS_OFS, 0);
        `CHK("nine_bits", 2'h2, q[1:0])
        @(posedge core_clk);
        rst <= 1'b1;
        @(negedge core_clk);
        `CHK("rst_out", 8'h01, {rx_level, rx_irq_req, queue_enable, full_duplex, irq, waitrequest})
        @(posedge core_clk);
        rst <= 1'b0;
        bus(0, `QUEUE_SETUP_OFS, 0);
        `CHK("rst_qsetup", 32'h0, q)
        finish_test();
    end
endmodule : testbench
`default_nettype wire
